// ### srg_host_model.sv
/*
 * Bus host model issuing single-phase and two-phase burst target accesses to the block.
 * Assumes the block samples on the rising edge of ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_host_model import srg_pkg::*; (
	input  wire logic         ref_clk,
	input  wire srg_bus_out_s bus_out,
	output var  srg_bus_in_s  bus_in
);
	initial begin
		bus_in = '{frame_n: 1'b1, irdy_n: 1'b1, idsel: 1'b0,
			cbe_n: 4'hF, ad: 32'hA5A5A5A5};
	end

	// Address phase, one data phase, then idle; waits counts edges to TRDY
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata,
		output int waits);
		waits = 0;
		@(posedge ref_clk);
		#1;
		bus_in.frame_n = 1'b0;
		bus_in.idsel   = cmd[3];
		bus_in.cbe_n   = cmd;
		bus_in.ad      = addr;
		@(posedge ref_clk);
		#1;
		bus_in.frame_n = 1'b1;
		bus_in.irdy_n  = 1'b0;
		bus_in.idsel   = 1'b0;
		bus_in.cbe_n   = 4'h0;
		// Read: line released, so show a changed pattern
		bus_in.ad      = cmd[0] ? wdata : ~addr;
		do begin
			@(posedge ref_clk);
			waits++;
		end while (bus_out.trdy_n !== 1'b0 && waits < 20);
		rdata = bus_out.ad;
		#1;
		bus_in.irdy_n = 1'b1;
		bus_in.cbe_n  = 4'hF;
		bus_in.ad     = ~bus_in.ad;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// Two-phase burst write; waits counts edges to TRDY over both phases
	task automatic wr2(input logic [31:0] addr, input logic [31:0] d0,
		input logic [31:0] d1, output int waits);
		waits = 0;
		@(posedge ref_clk);
		#1;
		bus_in.frame_n = 1'b0;
		bus_in.idsel   = 1'b0;
		bus_in.cbe_n   = SRG_CMD_MEM_WR;
		bus_in.ad      = addr;
		@(posedge ref_clk);
		#1;
		bus_in.irdy_n = 1'b0;
		bus_in.cbe_n  = 4'h0;
		bus_in.ad     = d0;
		do begin
			@(posedge ref_clk);
			waits++;
		end while (bus_out.trdy_n !== 1'b0 && waits < 20);
		#1;
		bus_in.frame_n = 1'b1;
		bus_in.ad      = d1;
		do begin
			@(posedge ref_clk);
			waits++;
		end while (bus_out.trdy_n !== 1'b0 && waits < 40);
		#1;
		bus_in.irdy_n = 1'b1;
		bus_in.cbe_n  = 4'hF;
		bus_in.ad     = ~bus_in.ad;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
endmodule // srg_host_model
`default_nettype wire

// ### srg_pkg.sv
/*
 * Shared constants and carriers for the system reset and pin direction
 * register block. Assumes a 32-bit synchronous target bus on ref_clk.
 */
`default_nettype none
package srg_pkg;

	// Register offsets within the host register window
	localparam logic [11:0] SRG_CTRL_OFF = 12'h028;
	localparam logic [11:0] SRG_PINS_OFF = 12'h02C;
	localparam logic [11:0] SRG_CFG_ID_OFF = 12'h000;
	localparam int          SRG_WIN_LSB = 12;

	// Control register fields and the pins register value field
	localparam int SRG_SWRST_BIT = 24;
	localparam int SRG_WAIT_LSB  = 16;
	localparam int SRG_WAIT_W    = 3;
	localparam int SRG_DIR_LSB   = 0;
	localparam int SRG_DIR_W     = 8;
	localparam int SRG_PIN_LSB   = 24;

	// Byte lanes carrying each field
	localparam int SRG_LANE_SWRST = 3;
	localparam int SRG_LANE_WAIT  = 2;
	localparam int SRG_LANE_DIR   = 0;
	localparam int SRG_LANE_PIN   = 3;

	// Reset values
	localparam logic                  SRG_SWRST_RST = 1'b0;
	localparam logic [SRG_WAIT_W-1:0] SRG_WAIT_RST  = 3'h0;
	localparam logic [SRG_DIR_W-1:0]  SRG_DIR_RST   = 8'hFF;
	localparam logic [SRG_DIR_W-1:0]  SRG_PIN_RST   = 8'hF0;

	// Bits of the control word that read as zero, the zero word and the burst address step
	localparam logic [31:0] SRG_CTRL_RSV = 32'hFEF8FF00;
	localparam logic [31:0] SRG_ZERO     = 32'h00000000;
	localparam logic [31:0] SRG_ADDR_STEP = 32'h00000004;

	// Bus commands
	localparam logic [3:0] SRG_CMD_MEM_RD = 4'h6;
	localparam logic [3:0] SRG_CMD_MEM_WR = 4'h7;
	localparam logic [3:0] SRG_CMD_CFG_RD = 4'hA;
	localparam logic [3:0] SRG_CMD_CFG_WR = 4'hB;

	typedef enum logic [1:0] {
		SRG_T_MEM_RD,
		SRG_T_MEM_WR,
		SRG_T_CFG_RD,
		SRG_T_CFG_WR
	} srg_kind_e;

	// Bus signals sampled by the target
	typedef struct packed {
		logic        frame_n;
		logic        irdy_n;
		logic        idsel;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} srg_bus_in_s;

	// Bus signals driven by the target, all registered
	typedef struct packed {
		logic [31:0] ad;
		logic        ad_oe_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        ctl_oe_n;
	} srg_bus_out_s;

endpackage
`default_nettype wire

// ### srg_sync2.sv
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the levels are quasi-static relative to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_sync2 import srg_pkg::*; #(
	parameter int WIDTH = SRG_DIR_W
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // srg_sync2
`default_nettype wire

// ### srg_top.sv
/*
 * System reset, target wait-state and general pin direction registers,
 * with the bus target that reaches them.
 * Assumes bus inputs are synchronous to ref_clk; pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_top import srg_pkg::*; #(
	parameter logic [31:0] MEM_BASE = 32'h00000000,
	parameter logic [31:0] ID_WORD  = 32'h5A5A1234  // Arbitrary value
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire srg_bus_in_s          bus_in,
	output var  srg_bus_out_s         bus_out,
	input  wire logic                 dma_req,
	output var  logic                 master_req_n,
	output var  logic                 sw_reset_n,
	input  wire logic [SRG_DIR_W-1:0] general_pins_in,
	output var  logic [SRG_DIR_W-1:0] general_pins_out,
	output var  logic [SRG_DIR_W-1:0] general_pins_oe_n
);

	typedef enum logic [1:0] {
		SRG_S_IDLE,
		SRG_S_WAIT,
		SRG_S_DATA,
		SRG_S_TURN
	} srg_state_e;

	srg_state_e            st_q;
	srg_kind_e             kind_q;
	logic [31:0]           addr_q;
	logic                  frame_prev_q;
	logic [SRG_WAIT_W-1:0] target_wait_count_q;
	logic [SRG_DIR_W-1:0]  pin_direction_mask_q;
	logic [SRG_DIR_W-1:0]  pin_value_field_q;
	logic [SRG_DIR_W-1:0]  pins_sync;
	logic                  wait_zero;
	logic                  wait_load;
	logic                  addr_phase;
	logic                  mem_hit;
	logic                  cfg_hit;
	logic                  xfer_done;
	logic                  wr_ctrl;
	logic                  wr_pins;

	function automatic logic [11:0] win_off(input logic [31:0] a);
		win_off = {a[SRG_WIN_LSB-1:2], 2'b00};
	endfunction

	function automatic logic lane_on(input logic [3:0] be_n, input int lane);
		lane_on = !be_n[lane];
	endfunction

	// Read data for the current word
	function automatic logic [31:0] rd_word(input srg_kind_e k,
		input logic [31:0] a);
		logic [31:0] w;
		w = SRG_ZERO;
		if (k == SRG_T_CFG_RD) begin
			if (win_off(a) == SRG_CFG_ID_OFF)
				w = ID_WORD;
		end else if (win_off(a) == SRG_CTRL_OFF) begin
			w[SRG_SWRST_BIT] = sw_reset_n;
			w[SRG_WAIT_LSB +: SRG_WAIT_W] = target_wait_count_q;
			w[SRG_DIR_LSB +: SRG_DIR_W] = pin_direction_mask_q;
			w = w & ~SRG_CTRL_RSV;
		end else if (win_off(a) == SRG_PINS_OFF) begin
			w[SRG_PIN_LSB +: SRG_DIR_W] = pins_sync;
		end
		rd_word = w;
	endfunction

	srg_sync2 #(
		.WIDTH (SRG_DIR_W)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in (general_pins_in),
		.sync_out (pins_sync)
	);

	srg_wait_ctr u_wait (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.load     (wait_load),
		.load_val (target_wait_count_q),
		.zero     (wait_zero)
	);

	// Address phase decode, independent of software reset
	assign addr_phase = !bus_in.frame_n && frame_prev_q;
	assign mem_hit = addr_phase
		&& (bus_in.ad[31:SRG_WIN_LSB] == MEM_BASE[31:SRG_WIN_LSB])
		&& (bus_in.cbe_n == SRG_CMD_MEM_RD
		|| bus_in.cbe_n == SRG_CMD_MEM_WR);
	assign cfg_hit = addr_phase && bus_in.idsel
		&& (bus_in.cbe_n == SRG_CMD_CFG_RD
		|| bus_in.cbe_n == SRG_CMD_CFG_WR);
	assign xfer_done = (st_q == SRG_S_DATA) && !bus_in.irdy_n;
	assign wait_load = ((st_q == SRG_S_IDLE) && (mem_hit || cfg_hit))
		|| (xfer_done && !bus_in.frame_n);
	assign wr_ctrl = xfer_done && (kind_q == SRG_T_MEM_WR)
		&& (win_off(addr_q) == SRG_CTRL_OFF);
	assign wr_pins = xfer_done && (kind_q == SRG_T_MEM_WR)
		&& (win_off(addr_q) == SRG_PINS_OFF);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			frame_prev_q <= 1'b1;
		else
			frame_prev_q <= bus_in.frame_n;
	end

	// Target sequencer, never held by software reset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q    <= SRG_S_IDLE;
			kind_q  <= SRG_T_MEM_RD;
			addr_q  <= SRG_ZERO;
			bus_out <= '{ad: SRG_ZERO, ad_oe_n: 1'b1, trdy_n: 1'b1,
				devsel_n: 1'b1, stop_n: 1'b1, ctl_oe_n: 1'b1};
		end else begin
			unique case (st_q)
				SRG_S_IDLE: begin
					if (mem_hit || cfg_hit) begin
						addr_q <= bus_in.ad;
						unique case (bus_in.cbe_n)
							SRG_CMD_MEM_WR: kind_q <= SRG_T_MEM_WR;
							SRG_CMD_CFG_RD: kind_q <= SRG_T_CFG_RD;
							SRG_CMD_CFG_WR: kind_q <= SRG_T_CFG_WR;
							default:        kind_q <= SRG_T_MEM_RD;
						endcase
						bus_out.devsel_n <= 1'b0;
						bus_out.stop_n   <= 1'b1;
						bus_out.ctl_oe_n <= 1'b0;
						st_q <= SRG_S_WAIT;
					end
				end
				SRG_S_WAIT: begin
					if (wait_zero) begin
						bus_out.trdy_n <= 1'b0;
						if (kind_q == SRG_T_MEM_RD
							|| kind_q == SRG_T_CFG_RD) begin
							bus_out.ad      <= rd_word(kind_q, addr_q);
							bus_out.ad_oe_n <= 1'b0;
						end
						st_q <= SRG_S_DATA;
					end
				end
				SRG_S_DATA: begin
					if (!bus_in.irdy_n) begin
						bus_out.trdy_n <= 1'b1;
						if (bus_in.frame_n) begin
							bus_out.devsel_n <= 1'b1;
							st_q <= SRG_S_TURN;
						end else begin
							addr_q <= addr_q + SRG_ADDR_STEP;
							st_q <= SRG_S_WAIT;
						end
					end
				end
				SRG_S_TURN: begin
					bus_out.ad_oe_n  <= 1'b1;
					bus_out.ctl_oe_n <= 1'b1;
					st_q <= SRG_S_IDLE;
				end
			endcase
		end
	end

	// Software reset bit, cleared by power-on reset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			sw_reset_n <= SRG_SWRST_RST;
		else if (wr_ctrl && lane_on(bus_in.cbe_n, SRG_LANE_SWRST))
			sw_reset_n <= bus_in.ad[SRG_SWRST_BIT];
	end

	// Wait count and direction mask
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			target_wait_count_q  <= SRG_WAIT_RST;
			pin_direction_mask_q <= SRG_DIR_RST;
		end else if (!sw_reset_n) begin
			target_wait_count_q  <= SRG_WAIT_RST;
			pin_direction_mask_q <= SRG_DIR_RST;
		end else if (wr_ctrl) begin
			if (lane_on(bus_in.cbe_n, SRG_LANE_WAIT))
				target_wait_count_q <=
					bus_in.ad[SRG_WAIT_LSB +: SRG_WAIT_W];
			if (lane_on(bus_in.cbe_n, SRG_LANE_DIR))
				pin_direction_mask_q <=
					bus_in.ad[SRG_DIR_LSB +: SRG_DIR_W];
		end
	end

	// Pin output values; input pins keep their stored value
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			pin_value_field_q <= SRG_PIN_RST;
		else if (!sw_reset_n)
			pin_value_field_q <= SRG_PIN_RST;
		else if (wr_pins && lane_on(bus_in.cbe_n, SRG_LANE_PIN))
			pin_value_field_q <= (pin_value_field_q & pin_direction_mask_q)
				| (bus_in.ad[SRG_PIN_LSB +: SRG_DIR_W]
				& ~pin_direction_mask_q);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			general_pins_out  <= SRG_PIN_RST;
			general_pins_oe_n <= SRG_DIR_RST;
		end else begin
			general_pins_out  <= pin_value_field_q;
			general_pins_oe_n <= pin_direction_mask_q;
		end
	end

	// Master request gated by software reset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			master_req_n <= 1'b1;
		else
			master_req_n <= !(dma_req && sw_reset_n);
	end

	// Helpers for checks
	logic [SRG_WAIT_W:0]   wait_cyc_q;
	logic [SRG_WAIT_W-1:0] lat_wait_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cyc_q <= '0;
			lat_wait_q <= SRG_WAIT_RST;
		end else begin
			wait_cyc_q <= (st_q == SRG_S_WAIT) ? wait_cyc_q + 4'h1 : 4'h0;
			if (wait_load)
				lat_wait_q <= target_wait_count_q;
		end
	end

	default clocking srg_cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_por_reset_bit: assert property (
		$fell(sys_rst) |-> !sw_reset_n && general_pins_oe_n == SRG_DIR_RST)
		else $error("reset bit not cleared at power-on");

	a_reset_write_bit: assert property (
		wr_ctrl && !bus_in.cbe_n[SRG_LANE_SWRST]
		|=> sw_reset_n == $past(bus_in.ad[SRG_SWRST_BIT]))
		else $error("reset bit did not follow write");

	a_reset_defaults: assert property (
		!sw_reset_n |=> target_wait_count_q == SRG_WAIT_RST
		&& pin_direction_mask_q == SRG_DIR_RST)
		else $error("fields not at default in reset");

	a_reset_pins_hold: assert property (
		!sw_reset_n ##1 !sw_reset_n |=> pin_value_field_q == SRG_PIN_RST)
		else $error("pin values written during reset");

	a_target_in_reset: assert property (
		(st_q == SRG_S_IDLE) && (mem_hit || cfg_hit)
		|=> !bus_out.devsel_n && !bus_out.ctl_oe_n)
		else $error("target did not claim access");

	a_last_phase_end: assert property (
		xfer_done && bus_in.frame_n |=> bus_out.devsel_n && bus_out.stop_n
		##1 bus_out.ctl_oe_n && bus_out.ad_oe_n)
		else $error("last data phase not closed cleanly");

	a_no_master_req: assert property (
		!sw_reset_n |=> master_req_n)
		else $error("master request during reset");

	a_wait_latency: assert property (
		$fell(bus_out.trdy_n) |-> $past(wait_cyc_q) == {1'b0, lat_wait_q})
		else $error("wrong wait-state count before ready");

	a_input_ignore: assert property (
		sw_reset_n |=> ((pin_value_field_q ^ $past(pin_value_field_q))
		& $past(pin_direction_mask_q)) == 8'h00)
		else $error("input pin value changed by write");

	a_reserved_zero: assert property (
		(st_q == SRG_S_DATA) && kind_q == SRG_T_MEM_RD
		&& win_off(addr_q) == SRG_CTRL_OFF
		|-> (bus_out.ad & SRG_CTRL_RSV) == SRG_ZERO)
		else $error("reserved control bits not zero");

	c_burst: cover property (xfer_done && !bus_in.frame_n);
	c_enter_reset: cover property ($fell(sw_reset_n));
	c_leave_reset: cover property ($rose(sw_reset_n));
	c_wait_phase: cover property ($fell(bus_out.trdy_n) && lat_wait_q != 3'h0);

endmodule // srg_top
`default_nettype wire

// ### srg_wait_ctr.sv
/*
 * Wait-state down counter for target data phases.
 * Assumes load is a one-cycle request at the start of each data phase.
 */
`timescale 1ns/1ps
`default_nettype none
module srg_wait_ctr import srg_pkg::*; (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  load,
	input  wire logic [SRG_WAIT_W-1:0] load_val,
	output var  logic                  zero
);

	logic [SRG_WAIT_W-1:0] cnt_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= SRG_WAIT_RST;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != SRG_WAIT_RST) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	assign zero = (cnt_q == SRG_WAIT_RST);

endmodule // srg_wait_ctr
`default_nettype wire

// ### tb_system_reset_gpio_dir_control.sv
/*
 * Self-checking bench for the reset, wait-state and pin direction block.
 * Assumes srg_host_model drives the bus; pins resolved here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_system_reset_gpio_dir_control import srg_pkg::*;;
	localparam logic [31:0] ID_EXP = 32'h3C3C0001;  // Arbitrary value
	localparam logic [31:0] A_CTRL = 32'(SRG_CTRL_OFF);
	localparam logic [31:0] A_PINS = 32'(SRG_PINS_OFF);

	logic         ref_clk;
	logic         sys_rst;
	srg_bus_in_s  bus_in;
	srg_bus_out_s bus_out;
	logic         dma_req;
	logic         master_req_n;
	logic         sw_reset_n;
	logic [7:0]   pins_in;
	logic [7:0]   pins_out;
	logic [7:0]   pins_oe_n;
	logic [7:0]   ext_pins;
	logic [31:0]  rng;
	logic [31:0]  rd;
	logic [31:0]  r;
	logic [31:0]  ctrl_m;
	logic [7:0]   pin_m;
	int           miscompares;
	int           num_checks;
	int           bw;

	// Pin level: driven value where output, external level where input
	assign pins_in = (pins_out & ~pins_oe_n) | (ext_pins & pins_oe_n);

	srg_top #(.MEM_BASE(32'h00000000), .ID_WORD(ID_EXP)) u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_in(bus_in),
		.bus_out(bus_out), .dma_req(dma_req), .master_req_n(master_req_n),
		.sw_reset_n(sw_reset_n), .general_pins_in(pins_in),
		.general_pins_out(pins_out), .general_pins_oe_n(pins_oe_n)
	);

	srg_host_model u_host (
		.ref_clk(ref_clk), .bus_out(bus_out), .bus_in(bus_in)
	);

	always #20 ref_clk = ~ref_clk;

	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic acc(input logic [3:0] cmd, input logic [31:0] a,
		input logic [31:0] v);
		int w;
		u_host.xfer(cmd, a, v, rd, w);
		check(32'(w), 32'(2 + ctrl_m[18:16]));
		check(32'(bus_out.stop_n), 32'h00000001);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		acc(SRG_CMD_MEM_RD, a, 32'h00000000);
		check(rd, exp);
	endtask

	task automatic wr_ctrl(input logic [31:0] v);
		acc(SRG_CMD_MEM_WR, A_CTRL, v);
		if (ctrl_m[24] && v[24]) begin
			ctrl_m = v & ~SRG_CTRL_RSV;
		end else begin
			ctrl_m = {7'h00, v[24], 24'h0000FF};
			pin_m = 8'hF0;
		end
	endtask

	task automatic pins_chk(input logic [7:0] v);
		logic [7:0] lvl;
		acc(SRG_CMD_MEM_WR, A_PINS, {v, 24'h000000});
		if (ctrl_m[24]) begin
			pin_m = (pin_m & ctrl_m[7:0]) | (v & ~ctrl_m[7:0]);
		end
		lvl = (pin_m & ~ctrl_m[7:0]) | (ext_pins & ctrl_m[7:0]);
		repeat (3) tick();
		check(32'(pins_out), 32'(pin_m));
		acc(SRG_CMD_MEM_RD, A_PINS, 32'h00000000);
		check(32'(rd[31:24]), 32'(lvl));
		check(32'(pins_in), 32'(lvl));
	endtask

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		dma_req = 1'b1;
		ext_pins = 8'h5A;
		rng = 32'h00012B91;
		miscompares = 0;
		num_checks = 0;
		ctrl_m = 32'h000000FF;
		pin_m = 8'hF0;
		repeat (5) tick();
		sys_rst = 1'b0;
		check(32'(sw_reset_n), 32'h00000000);
		check(32'(master_req_n), 32'h00000001);
		check(32'(pins_oe_n), 32'h000000FF);
		rd_chk(A_CTRL, 32'h000000FF);
		acc(SRG_CMD_CFG_RD, 32'h00000000, 32'h00000000);
		check(rd, ID_EXP);
		acc(SRG_CMD_CFG_WR, SRG_ZERO, 32'hFFFFFFFF);
		acc(SRG_CMD_CFG_RD, A_PINS, SRG_ZERO);
		check(rd, SRG_ZERO);
		wr_ctrl(32'hFEFFFF00);
		rd_chk(A_CTRL, ctrl_m);
		pins_chk(8'h0F);
		wr_ctrl(32'hFFFFFF00);
		rd_chk(A_CTRL, 32'h010000FF);
		for (int i = 0; i < 8; i++) begin
			r = nxt();
			ext_pins = r[15:8];
			dma_req = r[16];
			wr_ctrl({7'h7F, 1'b1, 5'h1F, 3'(i), 8'hFF, r[7:0]});
			rd_chk(A_CTRL, ctrl_m);
			check(32'(pins_oe_n), 32'(ctrl_m[7:0]));
			pins_chk(r[31:24]);
			check(32'(master_req_n), 32'(!r[16]));
		end
		rd_chk(32'h00000100, 32'h00000000);
		dma_req = 1'b1;
		wr_ctrl(32'h00000000);
		check(32'(master_req_n), 32'h00000001);
		check(32'(pins_oe_n), 32'h000000FF);
		rd_chk(A_CTRL, 32'h000000FF);
		acc(SRG_CMD_CFG_RD, 32'h00000000, 32'h00000000);
		check(rd, ID_EXP);
		wr_ctrl(32'h01000000);
		rd_chk(A_CTRL, 32'h010000FF);
		wr_ctrl(32'h01030000);
		u_host.wr2(A_CTRL, SRG_ZERO, 32'h0F000000, bw);
		check(32'(bw), 32'(4 + 2 * ctrl_m[18:16]));
		ctrl_m = 32'h000000FF;
		pin_m = 8'hF0;
		check(32'(pins_out), 32'(pin_m));
		rd_chk(A_CTRL, ctrl_m);
		wr_ctrl(32'h01000000);
		tick();
		sys_rst = 1'b1;
		tick();
		check(32'(sw_reset_n), 32'h00000000);
		sys_rst = 1'b0;
		ctrl_m = 32'h000000FF;
		pin_m = 8'hF0;
		rd_chk(A_CTRL, ctrl_m);
		close_out();
	end

	initial begin
		#200000;
		miscompares++;
		close_out();
	end
endmodule // tb_system_reset_gpio_dir_control
`default_nettype wire
